// [dcds_checker.sv]
// Purpose: port-level assertions for the command sequencer
// Assumes: bound to dcds_sequencer, one clock domain
// Notes: locations come from the shared constants header
`timescale 1ns/1ps
`include "dcds_consts.vh"

module dcds_checker (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // host and drive inputs
  input wire [`DCDS_FN_W-1:0] func_code,
  input wire reg_write,
  input wire unit_ready,
  input wire on_cylinder,
  input wire end_of_block_pulse,
  // sequencer outputs
  input wire go_reg,
  input wire [`DCDS_PC_W-1:0] pc_reg,
  input wire end_go_clear,
  input wire attention_flag,
  input wire [15:0] error_reg_one
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_pc_idle: assert property (!go_reg |-> pc_reg == `DCDS_PC_START)
    else $error("pc away from start while idle");
  chk_fn_jump: assert property ($rose(go_reg) |=> pc_reg == {4'h0, func_code[3:0]} + 8'h01)
    else $error("pc did not load function location");
  chk_nop_path: assert property (go_reg && !func_code[4] && pc_reg == 8'h01
    |=> pc_reg == `DCDS_PC_END)
    else $error("no-op did not branch to end");
  chk_imm_end: assert property (go_reg && pc_reg == `DCDS_PC_END
    |=> !go_reg && end_go_clear && pc_reg == `DCDS_PC_START)
    else $error("end location did not clear go");
  chk_data_go: assert property ($rose(go_reg) && func_code[4] |-> ##2 pc_reg == `DCDS_PC_DATA)
    else $error("data command missed shared routine");
  chk_ready_wait: assert property (go_reg && pc_reg == `DCDS_PC_DATA && !unit_ready
    |=> pc_reg == `DCDS_PC_DATA)
    else $error("data routine ran without unit ready");
  chk_search_loop: assert property (go_reg && pc_reg == `DCDS_PC_DATA_SEARCH
    && !end_of_block_pulse |=> pc_reg == `DCDS_PC_DATA_SEARCH)
    else $error("search loop left early");
  chk_ebl_end: assert property (go_reg && pc_reg == `DCDS_PC_DATA_SEARCH && end_of_block_pulse
    |=> pc_reg == `DCDS_PC_DATA_BLOCK ##1 pc_reg == `DCDS_PC_END)
    else $error("end of block did not finish command");
  chk_ata_end: assert property (go_reg && pc_reg == `DCDS_PC_ATA_END
    |=> !go_reg && attention_flag && pc_reg == `DCDS_PC_START)
    else $error("attention end did not set flag and clear go");
  chk_motion_wait: assert property (go_reg && pc_reg == `DCDS_PC_MOTION_WAIT && !on_cylinder
    |=> pc_reg == `DCDS_PC_MOTION_WAIT)
    else $error("motion ended before on cylinder");
  chk_modify_ref: assert property (go_reg && reg_write |=> error_reg_one[`DCDS_ER1_RMR_BIT])
    else $error("write during command not refused");
endmodule // dcds_checker

// [dcds_consts.vh]
// Purpose: constants for the disk command dispatch sequencer
// Assumes: one clock, inputs synchronous to mclk
// Notes: sequencer addresses are hexadecimal locations of the program store
`ifndef DCDS_CONSTS_VH
`define DCDS_CONSTS_VH

`define DCDS_PC_W 8
`define DCDS_PC_START 8'h00
`define DCDS_PC_END 8'h7e
`define DCDS_PC_ATA_END 8'h7f
`define DCDS_PC_DRV_CLR 8'h7d
`define DCDS_PC_DATA 8'h80
`define DCDS_PC_DATA_SEARCH 8'h81
`define DCDS_PC_DATA_BLOCK 8'h82
`define DCDS_PC_MOTION_WAIT 8'h90
`define DCDS_PC_FN_LAST 8'h10

`define DCDS_FN_W 5
`define DCDS_FN_DATA_BIT 4

// function codes, low four bits (data_command_bit excluded)
`define DCDS_FN_NOP 4'h0
`define DCDS_FN_SEEK 4'h2
`define DCDS_FN_RECAL 4'h3
`define DCDS_FN_DRV_CLR 4'h4
`define DCDS_FN_RELEASE 4'h5
`define DCDS_FN_OFFSET 4'h6
`define DCDS_FN_RTC 4'h7
`define DCDS_FN_PRESET 4'h8
`define DCDS_FN_PACK_ACK 4'h9
`define DCDS_FN_SEARCH 4'hc

// test condition selects (one of sixteen)
`define DCDS_TST_W 4
`define DCDS_TST_DATA_CMD 4'h0
`define DCDS_TST_UNIT_READY 4'h3
`define DCDS_TST_ON_CYL 4'h5
`define DCDS_TST_EBL 4'h7

// register widths and field positions
`define DCDS_REG_W 16
`define DCDS_DS_VV_BIT 6
`define DCDS_DS_ERR_BIT 14
`define DCDS_DS_ATA_BIT 15
`define DCDS_DS_CLR_MASK 16'h3fff
`define DCDS_OF_CLR_MASK 16'he37f
`define DCDS_ER1_RMR_BIT 2
`define DCDS_ZERO16 16'h0000

`endif

// [dcds_drive_model.sv]
// Purpose: drive and formatter stand-in answering the sequencer
// Assumes: lag of at least one cycle
// Notes: heads dip off cylinder on each motion, one block per search
`timescale 1ns/1ps
`include "dcds_consts.vh"

module dcds_drive_model (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // sequencer view
  input wire [7:0] pc_reg,
  input wire en_search_reg,
  input wire [3:0] lag,
  // drive answers
  output reg on_cylinder,
  output reg end_of_block_pulse
);
  reg [3:0] cnt_reg;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      on_cylinder <= 1'b1;
      end_of_block_pulse <= 1'b0;
      cnt_reg <= 4'h0;
    end else begin
      end_of_block_pulse <= 1'b0;
      if (pc_reg == `DCDS_PC_MOTION_WAIT || en_search_reg) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (pc_reg == `DCDS_PC_MOTION_WAIT) on_cylinder <= (cnt_reg > lag);
        if (en_search_reg && cnt_reg == lag) end_of_block_pulse <= 1'b1;
      end else begin
        cnt_reg <= 4'h0;
      end
    end
  end
endmodule // dcds_drive_model

// [dcds_sequencer.v]
// Purpose: command sequencer of a disk drive adapter; dispatches on the function code
// Assumes: single clock mclk, nrst async active low, host strobes synchronous
// Notes: program counter model of the microcode; positioning and formatting elsewhere
//
// Summary of operation
// [RULE1] Program counter held at zero while GO is clear.
// [RULE2] First clock after GO: jump to function address, data bit excluded.
// [RULE3] Data command bit is one of sixteen branch test conditions.
// [RULE4] Immediate commands act on decode, then end by clearing GO.
// [RULE5] Immediate commands branch from function location to end, asserting go clear.
// [RULE6] Head motion commands run sequence, set attention, clear GO.
// [RULE7] Offset and centerline return only set attention and clear GO.
// [RULE8] Data commands go to location 128, then loop while search enabled.
// [RULE9] On end-of-block pulse the sequencer continues and clears GO.
// [RULE10] Six read, write and write check codes are data transfer commands.
// [RULE11] No-op only clears GO via start, function and end locations.
// [RULE12] Release does a drive clear then frees the drive for other port. Code pulses release_reg in the same cycle as drive_clear_reg.
// [RULE13] Read-in preset sets volume valid only for the issuing port.
// [RULE14] Preset clears cylinder and sector/track registers and offset bits 7,10-12.
// [RULE15] Drive clear keeps errors whose cause persists.
// [RULE16] Drive clear zeroes status bits 14-15, both error, summary, ecc registers.
// [RULE17] Host must pack acknowledge after medium online changes.
// [RULE18] Pack acknowledge sets volume valid then clears GO.
// [RULE19] Centerline return signal resets offset mode; preset drives it too.
// [RULE20] Register write during a command sets modify refused, error bit 2.
// [RULE21] Seek, search, recalibrate finish only after on-cylinder is seen.
// [RULE22] Program counter steps by one unless a branch loads a new address.
`timescale 1ns/1ps
`include "dcds_consts.vh"

module dcds_sequencer #(
  parameter REG_W = `DCDS_REG_W
) (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // host command
  input wire go_set,
  input wire [`DCDS_FN_W-1:0] func_code,
  input wire port_sel,
  input wire reg_write,
  // register loads from host
  input wire cyl_load,
  input wire sec_load,
  input wire ofs_load,
  input wire [REG_W-1:0] host_wdata,
  // drive status inputs
  input wire unit_ready,
  input wire on_cylinder,
  input wire end_of_block_pulse,
  input wire medium_online,
  input wire [REG_W-1:0] err_cause_one,
  input wire [REG_W-1:0] err_cause_two,
  input wire [REG_W-1:0] ecc_load_data,
  input wire ecc_load,
  // sequencer state
  output reg go_reg,
  output reg [`DCDS_PC_W-1:0] pc_reg,
  output reg end_go_clear,
  output reg attention_flag,
  output reg en_search_reg,
  output reg offset_mode_reg,
  output reg centerline_return_signal,
  output reg release_reg,
  output reg drive_clear_reg,
  output reg set_pulse_reg,
  // adapter registers
  output reg [REG_W-1:0] desired_cylinder_reg,
  output reg [REG_W-1:0] desired_sector_track_reg,
  output reg [REG_W-1:0] offset_reg,
  output reg [REG_W-1:0] drive_status_reg,
  output reg [REG_W-1:0] drive_status_b_reg,
  output reg [REG_W-1:0] error_reg_one,
  output reg [REG_W-1:0] error_reg_two,
  output reg [REG_W-1:0] attention_summary_reg,
  output reg [REG_W-1:0] ecc_pattern_reg
);

  localparam [`DCDS_FN_W-2:0] FN_LOW_ZERO = 4'h0;
  localparam [1:0] CLS_IMM = 2'h0;
  localparam [1:0] CLS_CLR = 2'h1;
  localparam [1:0] CLS_POS = 2'h2;
  localparam [1:0] CLS_MOT = 2'h3;

  wire [`DCDS_FN_W-2:0] fn_low;
  wire data_cmd;
  wire tst_hit;
  wire [15:0] tst_cond;
  reg [`DCDS_TST_W-1:0] tst_sel;
  reg [`DCDS_PC_W-1:0] pc_next;
  reg mol_d_reg;
  reg motion_seen_reg;
  wire fn_clear;
  reg [1:0] fn_class;
  wire fn_motion;
  wire fn_pos_only;

  assign fn_low = func_code[`DCDS_FN_W-2:0];
  assign data_cmd = func_code[`DCDS_FN_DATA_BIT];
  // [RULE10] data bit set selects read, read hdr, write check, write check hdr, write, write hdr
  assign fn_pos_only = (fn_class == CLS_POS);
  assign fn_motion = (fn_class == CLS_MOT);
  assign fn_clear = (fn_class == CLS_CLR);

  // command class from the low function bits; unknown codes end at once
  always @* begin
    fn_class = CLS_IMM;
    case (fn_low)
      `DCDS_FN_DRV_CLR: begin
        fn_class = CLS_CLR;
      end
      `DCDS_FN_RELEASE: begin
        fn_class = CLS_CLR;
      end
      `DCDS_FN_OFFSET: begin
        fn_class = CLS_POS;
      end
      `DCDS_FN_RTC: begin
        fn_class = CLS_POS;
      end
      `DCDS_FN_SEEK: begin
        fn_class = CLS_MOT;
      end
      `DCDS_FN_RECAL: begin
        fn_class = CLS_MOT;
      end
      `DCDS_FN_SEARCH: begin
        fn_class = CLS_MOT;
      end
      default: begin
        fn_class = CLS_IMM;
      end
    endcase
  end

  // sixteen test conditions; unused ones tie low
  assign tst_cond = {8'h00, end_of_block_pulse, 1'b0, on_cylinder, 1'b0,
                     unit_ready, 2'b00, data_cmd};

  dcds_test_mux #(
    .N_TST(16)
  ) u_tst (
    .sel(tst_sel),
    .cond(tst_cond),
    .hit(tst_hit) // [RULE3]
  );

  // next program counter and test select
  always @* begin
    tst_sel = `DCDS_TST_DATA_CMD;
    pc_next = pc_reg + 8'h01; // [RULE22]
    if (!go_reg) begin
      pc_next = `DCDS_PC_START; // [RULE1]
    end else if (pc_reg == `DCDS_PC_START) begin
      pc_next = {FN_LOW_ZERO, fn_low} + 8'h01; // [RULE2]
    end else if (pc_reg <= `DCDS_PC_FN_LAST) begin
      tst_sel = `DCDS_TST_DATA_CMD;
      if (tst_hit) begin
        pc_next = `DCDS_PC_DATA; // [RULE8]
      end else if (fn_clear) begin
        pc_next = `DCDS_PC_DRV_CLR; // [RULE12]
      end else if (fn_pos_only) begin
        pc_next = `DCDS_PC_ATA_END; // [RULE7]
      end else if (fn_motion) begin
        pc_next = `DCDS_PC_MOTION_WAIT;
      end else begin
        pc_next = `DCDS_PC_END; // [RULE5] [RULE11]
      end
    end else if (pc_reg == `DCDS_PC_MOTION_WAIT) begin
      tst_sel = `DCDS_TST_ON_CYL;
      if (tst_hit && motion_seen_reg) begin
        pc_next = `DCDS_PC_ATA_END; // [RULE21]
      end else begin
        pc_next = pc_reg;
      end
    end else if (pc_reg == `DCDS_PC_DATA) begin
      tst_sel = `DCDS_TST_UNIT_READY;
      pc_next = tst_hit ? `DCDS_PC_DATA_SEARCH : pc_reg;
    end else if (pc_reg == `DCDS_PC_DATA_SEARCH) begin
      tst_sel = `DCDS_TST_EBL;
      pc_next = tst_hit ? `DCDS_PC_DATA_BLOCK : pc_reg; // [RULE9]
    end else if (pc_reg == `DCDS_PC_DATA_BLOCK) begin
      pc_next = `DCDS_PC_END;
    end else if (pc_reg == `DCDS_PC_END || pc_reg == `DCDS_PC_ATA_END) begin
      pc_next = `DCDS_PC_START;
    end else if (pc_reg == `DCDS_PC_DRV_CLR) begin
      pc_next = `DCDS_PC_END;
    end
  end

  // sequencer state
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      go_reg <= 1'b0;
      pc_reg <= `DCDS_PC_START;
      end_go_clear <= 1'b0;
      attention_flag <= 1'b0;
      en_search_reg <= 1'b0;
      set_pulse_reg <= 1'b0;
      motion_seen_reg <= 1'b0;
      // online level, so leaving reset does not look like a medium change
      mol_d_reg <= 1'b1;
    end else begin
      pc_reg <= pc_next;
      mol_d_reg <= medium_online;
      set_pulse_reg <= go_reg && (pc_reg == `DCDS_PC_START);
      end_go_clear <= go_reg && (pc_reg == `DCDS_PC_END || pc_reg == `DCDS_PC_ATA_END);
      en_search_reg <= go_reg && (pc_reg == `DCDS_PC_DATA_SEARCH); // [RULE8]
      // on-cylinder must drop once before a motion finish counts
      if (!go_reg) begin
        motion_seen_reg <= 1'b0;
      end else if (pc_reg == `DCDS_PC_MOTION_WAIT && !on_cylinder) begin
        motion_seen_reg <= 1'b1;
      end
      // clear at end wins over a go_set in the same cycle
      if (go_reg && (pc_reg == `DCDS_PC_END || pc_reg == `DCDS_PC_ATA_END)) begin
        go_reg <= 1'b0; // [RULE4] [RULE5] [RULE9] [RULE18]
      end else if (go_set) begin
        go_reg <= 1'b1;
      end
      // attention: set wins over drive clear
      if (go_reg && pc_reg == `DCDS_PC_ATA_END) begin
        attention_flag <= 1'b1; // [RULE6] [RULE7]
      end else if (mol_d_reg != medium_online) begin
        attention_flag <= 1'b1;
      end else if (drive_clear_reg) begin
        attention_flag <= 1'b0;
      end
    end
  end

  // command side effects: one-cycle strobes from the start and drive clear locations, and the offset mode level set from start
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      offset_mode_reg <= 1'b0;
      centerline_return_signal <= 1'b0;
      release_reg <= 1'b0;
      drive_clear_reg <= 1'b0;
    end else begin
      centerline_return_signal <= go_reg && (pc_reg == `DCDS_PC_START) && !data_cmd &&
                                  (fn_low == `DCDS_FN_RTC || fn_low == `DCDS_FN_PRESET);
      drive_clear_reg <= go_reg && (pc_reg == `DCDS_PC_DRV_CLR); // [RULE12] [RULE16]
      release_reg <= go_reg && (pc_reg == `DCDS_PC_DRV_CLR) &&
                     (fn_low == `DCDS_FN_RELEASE) && !data_cmd; // [RULE12]
      if (centerline_return_signal) begin
        offset_mode_reg <= 1'b0; // [RULE19]
      end else if (go_reg && pc_reg == `DCDS_PC_START && !data_cmd &&
                   fn_low == `DCDS_FN_OFFSET) begin
        offset_mode_reg <= 1'b1;
      end
    end
  end

  wire at_func;
  wire is_preset;
  wire is_pack_ack;
  wire busy_write;
  wire err_any;
  assign at_func = go_reg && (pc_reg == `DCDS_PC_START) && !data_cmd;
  assign is_preset = at_func && (fn_low == `DCDS_FN_PRESET);
  assign is_pack_ack = at_func && (fn_low == `DCDS_FN_PACK_ACK);
  assign busy_write = reg_write && go_reg;
  assign err_any = (|error_reg_one) || (|error_reg_two);

  // address, offset and status registers
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      desired_cylinder_reg <= `DCDS_ZERO16;
      desired_sector_track_reg <= `DCDS_ZERO16;
      offset_reg <= `DCDS_ZERO16;
      drive_status_reg <= `DCDS_ZERO16;
      drive_status_b_reg <= `DCDS_ZERO16;
    end else begin
      if (is_preset) begin
        desired_cylinder_reg <= `DCDS_ZERO16; // [RULE14]
        desired_sector_track_reg <= `DCDS_ZERO16;
        offset_reg <= offset_reg & `DCDS_OF_CLR_MASK;
      end else begin
        if (cyl_load && !go_reg) begin
          desired_cylinder_reg <= host_wdata;
        end
        if (sec_load && !go_reg) begin
          desired_sector_track_reg <= host_wdata;
        end
        if (ofs_load && !go_reg) begin
          offset_reg <= host_wdata;
        end
      end
      // volume valid per port; lost when medium goes off line
      if ((is_preset || is_pack_ack) && !port_sel) begin
        drive_status_reg[`DCDS_DS_VV_BIT] <= 1'b1; // [RULE13] [RULE18]
      end else if (!medium_online) begin
        drive_status_reg[`DCDS_DS_VV_BIT] <= 1'b0; // [RULE17]
      end
      if ((is_preset || is_pack_ack) && port_sel) begin
        drive_status_b_reg[`DCDS_DS_VV_BIT] <= 1'b1; // [RULE13]
      end else if (!medium_online) begin
        drive_status_b_reg[`DCDS_DS_VV_BIT] <= 1'b0;
      end
      // attention and error summary bits are set by their sources and hold until a drive clear
      if (drive_clear_reg) begin
        drive_status_reg[`DCDS_DS_ATA_BIT] <= 1'b0; // [RULE16]
        drive_status_reg[`DCDS_DS_ERR_BIT] <= 1'b0;
        drive_status_b_reg[`DCDS_DS_ATA_BIT] <= 1'b0;
        drive_status_b_reg[`DCDS_DS_ERR_BIT] <= 1'b0;
      end else begin
        if (attention_flag) begin
          drive_status_reg[`DCDS_DS_ATA_BIT] <= 1'b1;
          drive_status_b_reg[`DCDS_DS_ATA_BIT] <= 1'b1;
        end
        if (err_any) begin
          drive_status_reg[`DCDS_DS_ERR_BIT] <= 1'b1; // [RULE15]
          drive_status_b_reg[`DCDS_DS_ERR_BIT] <= 1'b1;
        end
      end
    end
  end

  // error registers: live causes re-set, so they survive a drive clear
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      error_reg_one <= `DCDS_ZERO16;
      error_reg_two <= `DCDS_ZERO16;
      attention_summary_reg <= `DCDS_ZERO16;
      ecc_pattern_reg <= `DCDS_ZERO16;
    end else begin
      if (drive_clear_reg) begin
        error_reg_one <= err_cause_one; // [RULE15] [RULE16]
        error_reg_two <= err_cause_two;
        attention_summary_reg <= `DCDS_ZERO16;
        ecc_pattern_reg <= `DCDS_ZERO16;
      end else begin
        error_reg_one <= error_reg_one | err_cause_one;
        error_reg_two <= error_reg_two | err_cause_two;
        attention_summary_reg[0] <= attention_summary_reg[0] | attention_flag;
        if (ecc_load) begin
          ecc_pattern_reg <= ecc_load_data;
        end
      end
      if (busy_write) begin
        error_reg_one[`DCDS_ER1_RMR_BIT] <= 1'b1; // [RULE20]
      end
    end
  end

endmodule // dcds_sequencer

// [dcds_sequencer_tb_top.sv]
// Purpose: self-checking bench for the command sequencer
// Assumes: inputs change 1 ns after the rising edge
// Notes: xorshift seeded with 51 drives lags and data
`timescale 1ns/1ps
`include "dcds_consts.vh"

module dcds_sequencer_tb_top;
  reg mclk = 1'b0;
  reg nrst = 1'b0;
  reg go_set = 1'b0;
  reg [4:0] func_code = 5'h00;
  reg port_sel = 1'b0;
  reg reg_write = 1'b0;
  reg cyl_load = 1'b0;
  reg sec_load = 1'b0;
  reg ofs_load = 1'b0;
  reg [15:0] host_wdata = 16'h0000;
  reg unit_ready = 1'b1;
  reg medium_online = 1'b1;
  reg [15:0] err_cause_one = 16'h0000;
  reg [15:0] err_cause_two = 16'h0000;
  reg [15:0] ecc_load_data = 16'h0000;
  reg ecc_load = 1'b0;
  reg [3:0] lag = 4'h1;
  wire on_cylinder, end_of_block_pulse, go_reg, end_go_clear, attention_flag, en_search_reg;
  wire offset_mode_reg, centerline_return_signal, release_reg, drive_clear_reg, set_pulse_reg;
  wire [7:0] pc_reg;
  wire [15:0] desired_cylinder_reg, desired_sector_track_reg, offset_reg, drive_status_reg;
  wire [15:0] drive_status_b_reg, error_reg_one, error_reg_two, attention_summary_reg;
  wire [15:0] ecc_pattern_reg;
  wire [11:0] mot = {`DCDS_FN_SEARCH, `DCDS_FN_RECAL, `DCDS_FN_SEEK};
  integer bad_count = 0;
  integer check_count = 0;
  integer i;
  reg [31:0] seed_reg = 32'h00000033;
  reg [15:0] v;
  reg [15:0] cmd_n = 16'h0000;
  reg [15:0] rel_n = 16'h0000;
  reg [15:0] setp_n = 16'h0000;
  reg [15:0] ctr_n = 16'h0000;

  always #5 mclk = ~mclk;

  // pulse counters; each pulse stands one cycle
  always @(posedge mclk) begin
    if (release_reg) rel_n <= rel_n + 16'h0001;
    if (set_pulse_reg) setp_n <= setp_n + 16'h0001;
    if (centerline_return_signal) ctr_n <= ctr_n + 16'h0001;
  end

  dcds_sequencer dcds_sequencer_inst (.mclk(mclk), .nrst(nrst), .go_set(go_set),
    .func_code(func_code), .port_sel(port_sel), .reg_write(reg_write), .cyl_load(cyl_load),
    .sec_load(sec_load), .ofs_load(ofs_load), .host_wdata(host_wdata), .unit_ready(unit_ready),
    .on_cylinder(on_cylinder), .end_of_block_pulse(end_of_block_pulse),
    .medium_online(medium_online), .err_cause_one(err_cause_one),
    .err_cause_two(err_cause_two), .ecc_load_data(ecc_load_data), .ecc_load(ecc_load),
    .go_reg(go_reg), .pc_reg(pc_reg), .end_go_clear(end_go_clear),
    .attention_flag(attention_flag), .en_search_reg(en_search_reg),
    .offset_mode_reg(offset_mode_reg), .centerline_return_signal(centerline_return_signal),
    .release_reg(release_reg), .drive_clear_reg(drive_clear_reg),
    .set_pulse_reg(set_pulse_reg), .desired_cylinder_reg(desired_cylinder_reg),
    .desired_sector_track_reg(desired_sector_track_reg), .offset_reg(offset_reg),
    .drive_status_reg(drive_status_reg), .drive_status_b_reg(drive_status_b_reg),
    .error_reg_one(error_reg_one), .error_reg_two(error_reg_two),
    .attention_summary_reg(attention_summary_reg), .ecc_pattern_reg(ecc_pattern_reg));
  dcds_drive_model dcds_drive_model_inst (.mclk(mclk), .nrst(nrst), .pc_reg(pc_reg),
    .en_search_reg(en_search_reg), .lag(lag), .on_cylinder(on_cylinder),
    .end_of_block_pulse(end_of_block_pulse));

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  function [15:0] preset_ofs(input [15:0] o);
    preset_ofs = o & `DCDS_OF_CLR_MASK;
  endfunction

  task tick(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask

  task chk(input string what, input [15:0] exp, input [15:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // one command; wr also tries a write and a load while go is set
  task cmd(input [4:0] fn, input wr);
    integer n;
    begin
      seed_reg = xs(seed_reg);
      lag = {2'b00, seed_reg[1:0]} + 4'h1;
      func_code = fn;
      cmd_n = cmd_n + 16'h0001;
      unit_ready = ~fn[4];
      go_set = 1'b1;
      tick(1);
      go_set = 1'b0;
      reg_write = wr;
      cyl_load = wr;
      host_wdata = seed_reg[31:16];
      tick(1);
      reg_write = 1'b0;
      cyl_load = 1'b0;
      n = 0;
      while (go_reg !== 1'b0 && n < 400) begin
        tick(1);
        n = n + 1;
        if (n == 3) unit_ready = 1'b1;
      end
      chk("go", 16'h0000, {15'h0, go_reg});
    end
  endtask

  task results;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  initial begin
    #200000;
    bad_count = bad_count + 1;
    results;
  end

  initial begin
    tick(20);
    nrst = 1'b1;
    tick(1);
    chk("pc", 16'h0000, {8'h00, pc_reg});
    for (i = 0; i < 4; i = i + 1) begin
      cmd(`DCDS_FN_NOP, 1'b0);
      tick(seed_reg[2:0]);
    end
    medium_online = 1'b0;
    tick(2);
    medium_online = 1'b1;
    port_sel = 1'b1;
    v = seed_reg[15:0] | 16'h1c80;
    host_wdata = v;
    cyl_load = 1'b1;
    sec_load = 1'b1;
    ofs_load = 1'b1;
    tick(1);
    cyl_load = 1'b0;
    sec_load = 1'b0;
    ofs_load = 1'b0;
    cmd(`DCDS_FN_PRESET, 1'b0);
    chk("cylinder", 16'h0000, desired_cylinder_reg);
    chk("sector", 16'h0000, desired_sector_track_reg);
    chk("offset", preset_ofs(v), offset_reg);
    chk("valid b", 16'h0001, {15'h0, drive_status_b_reg[`DCDS_DS_VV_BIT]});
    chk("valid a", 16'h0000, {15'h0, drive_status_reg[`DCDS_DS_VV_BIT]});
    port_sel = 1'b0;
    cmd(`DCDS_FN_PACK_ACK, 1'b0);
    chk("valid a", 16'h0001, {15'h0, drive_status_reg[`DCDS_DS_VV_BIT]});
    cmd(`DCDS_FN_DRV_CLR, 1'b0);
    chk("attention", 16'h0000, {15'h0, attention_flag});
    cmd(`DCDS_FN_OFFSET, 1'b0);
    chk("offset mode", 16'h0001, {15'h0, offset_mode_reg});
    chk("attention", 16'h0001, {15'h0, attention_flag});
    cmd(`DCDS_FN_PRESET, 1'b0);
    chk("offset mode", 16'h0000, {15'h0, offset_mode_reg});
    seed_reg = xs(seed_reg);
    err_cause_one = seed_reg[15:0] | 16'h0001;
    err_cause_two = seed_reg[31:16] | 16'h0001;
    ecc_load_data = seed_reg[15:0] | 16'h8000;
    ecc_load = 1'b1;
    tick(1);
    ecc_load = 1'b0;
    err_cause_one = 16'h0000;
    tick(2);
    chk("status top", 16'hc000, drive_status_reg & 16'hc000);
    cmd(`DCDS_FN_DRV_CLR, 1'b0);
    chk("error one", 16'h0000, error_reg_one);
    chk("error two", err_cause_two, error_reg_two);
    chk("ecc", 16'h0000, ecc_pattern_reg);
    chk("summary", 16'h0000, attention_summary_reg);
    err_cause_two = 16'h0000;
    cmd(`DCDS_FN_RELEASE, 1'b0);
    chk("error two", 16'h0000, error_reg_two);
    chk("release", 16'h0001, rel_n);
    chk("summary", 16'h0000, attention_summary_reg);
    chk("status top", 16'h0000, drive_status_reg & 16'hc000);
    chk("attention", 16'h0000, {15'h0, attention_flag});
    cmd(`DCDS_FN_RTC, 1'b0);
    chk("attention", 16'h0001, {15'h0, attention_flag});
    for (i = 0; i < 3; i = i + 1) begin
      cmd(`DCDS_FN_DRV_CLR, 1'b0);
      cmd({1'b0, mot[4*i +: 4]}, 1'b0);
      chk("attention", 16'h0001, {15'h0, attention_flag});
    end
    for (i = 0; i < 6; i = i + 1) begin
      cmd({1'b1, i[2:0], 1'b0}, i == 5);
    end
    chk("refused", 16'h0001, {15'h0, error_reg_one[`DCDS_ER1_RMR_BIT]});
    chk("cylinder", 16'h0000, desired_cylinder_reg);
    nrst = 1'b0;
    tick(2);
    chk("reset error", 16'h0000, error_reg_one);
    nrst = 1'b1;
    tick(1);
    chk("attention", 16'h0000, {15'h0, attention_flag});
    cmd(`DCDS_FN_NOP, 1'b0);
    chk("release", 16'h0001, rel_n);
    chk("set pulse", cmd_n, setp_n);
    chk("centerline", 16'h0003, ctr_n);
    results;
  end
endmodule // dcds_sequencer_tb_top

bind dcds_sequencer dcds_checker dcds_checker_inst (.mclk(mclk), .nrst(nrst),
  .func_code(func_code), .reg_write(reg_write), .unit_ready(unit_ready),
  .on_cylinder(on_cylinder), .end_of_block_pulse(end_of_block_pulse), .go_reg(go_reg),
  .pc_reg(pc_reg), .end_go_clear(end_go_clear), .attention_flag(attention_flag),
  .error_reg_one(error_reg_one));

// [dcds_test_mux.v]
// Purpose: sixteen-way branch test condition selector
// Assumes: condition bits are synchronous to mclk
// Notes: purely combinational, output registered by the caller
`timescale 1ns/1ps
`include "dcds_consts.vh"

module dcds_test_mux #(
  parameter N_TST = 16
) (
  // selection
  input wire [`DCDS_TST_W-1:0] sel,
  input wire [N_TST-1:0] cond,
  // result
  output wire hit
);

  assign hit = cond[sel];

endmodule // dcds_test_mux
